/* File: gwp_pkg.sv */
// Notes on behaviour
// - Halt write enters power down; clock-stop output stays high until a wake event.
// - In power down a falling edge on a selected nibble, or any edge on an enabled port E line, wakes the device.
// - Ports A-D wake per nibble on falling edge; port E lines on both edges.
// - A selected nibble with any pin held low cannot wake the device.
// - Port E line wake selection is a fixed option, not software writable.
// - Direction bit 1 makes the pin an input; software reads the pin level.
// - Direction bit 0 makes the pin a push-pull output from its data latch.
// - Reading an output pin returns the data latch, not the pin level.
// - V-axis line wakes set flag bits 3 and 4; port E read clears them.
// - Z-axis line wakes set flag bits 6 and 7; port E read clears them.
// - Reading the wake flag register clears flag bits 6 and 7.
// - After reset all data and direction registers hold all ones.
// - Bit set/clear is done by software as whole-port read, modify, rewrite.
// - Timer overflow never wakes; only pin wake sources end power down.
// - Output data is latched until rewritten; inputs are sampled on read.
package gwp_pkg;

  localparam int GWP_PORTS = 5;
  localparam int GWP_PW = 8;
  localparam int GWP_NIBBLES = 8;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] GWP_OFF_DATA_BASE = 8'h00;
  localparam logic [7:0] GWP_OFF_DIR_BASE = 8'h20;
  localparam logic [7:0] GWP_OFF_FLAGS = 8'h1C;
  localparam logic [7:0] GWP_OFF_HALT = 8'h40;
  localparam logic [7:0] GWP_OFF_NIB_SEL = 8'h44;
  localparam logic [7:0] GWP_OFF_IRQ_STAT = 8'h48;
  localparam logic [7:0] GWP_OFF_IRQ_MASK = 8'h4C;
  localparam logic [7:0] GWP_OFF_STEP = 8'h04;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int GWP_PORT_E = 4;
  localparam logic [7:0] GWP_E_MASK = 8'h7F;
  localparam logic [7:0] GWP_PORT_RST = 8'hFF;
  localparam logic [7:0] GWP_DIR_RST = 8'hFF;
  localparam logic [7:0] GWP_NIB_SEL_RST = 8'h00;
  localparam logic [1:0] GWP_IRQ_MASK_RST = 2'h0;
  localparam int GWP_FLAG_V1 = 3;
  localparam int GWP_FLAG_V2 = 4;
  localparam int GWP_FLAG_Z1 = 6;
  localparam int GWP_FLAG_Z2 = 7;
  localparam logic [7:0] GWP_FLAG_PIN_CLR = 8'hD8;
  localparam logic [7:0] GWP_FLAG_SELF_CLR = 8'hC0;
  localparam int GWP_IRQ_NIB = 0;
  localparam int GWP_IRQ_LINE = 1;
  localparam int GWP_TMR_LINE = 2;

  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic valid;
  } gwp_bus_req_t;

endpackage

/* File: gwp_port.sv */
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
module gwp_port
  import gwp_pkg::*;
#(
  parameter logic [6:0] E_WAKE_OPT = 7'h0F
) (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic [31:0] HRDATA,
  output logic HRESP,
  input wire logic [7:0] PA_I,
  output logic [7:0] PA_O,
  output logic [7:0] PA_OE,
  input wire logic [7:0] PB_I,
  output logic [7:0] PB_O,
  output logic [7:0] PB_OE,
  input wire logic [7:0] PC_I,
  output logic [7:0] PC_O,
  output logic [7:0] PC_OE,
  input wire logic [7:0] PD_I,
  output logic [7:0] PD_O,
  output logic [7:0] PD_OE,
  input wire logic [6:0] PE_I,
  output logic [6:0] PE_O,
  output logic [6:0] PE_OE,
  output logic TIMER_IN,
  output logic PWR_DOWN,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  gwp_bus_req_t req_ff;
  logic ready_ff;
  logic [31:0] rdata_ff;
  logic [31:0] rd_val;
  logic accept;
  logic wr_commit;
  logic rd_cap;

  assign accept = HSEL & HTRANS[1] & HREADY;
  assign wr_commit = req_ff.valid & req_ff.write & HREADY;
  assign rd_cap = req_ff.valid & ~req_ff.write;

  // Reads take one wait state so the data comes from a flop and
  // a write in the preceding data phase is already visible.
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      req_ff <= '0;
      ready_ff <= 1'b1;
      rdata_ff <= '0;
    end else begin
      if (accept) begin
        req_ff.addr <= HADDR[7:0];
        req_ff.write <= HWRITE;
        req_ff.valid <= 1'b1;
        ready_ff <= HWRITE;
      end else if (rd_cap) begin
        req_ff.valid <= 1'b0;
        ready_ff <= 1'b1;
      end else if (wr_commit) begin
        req_ff.valid <= 1'b0;
      end
      if (rd_cap) begin
        rdata_ff <= rd_val;
      end
    end
  end

  assign HREADYOUT = ready_ff;
  assign HRDATA = rdata_ff;
  assign HRESP = 1'b0;

  // ----------------------------------------------------------------
  // Ports: latches, direction, synchronisers
  // ----------------------------------------------------------------
  logic [7:0] pin_in [GWP_PORTS];
  logic [7:0] data_ff [GWP_PORTS];
  logic [7:0] dir_ff [GWP_PORTS];
  logic [7:0] oe_ff [GWP_PORTS];
  logic [7:0] meta_ff [GWP_PORTS];
  logic [7:0] sync_ff [GWP_PORTS];
  logic [7:0] prev_ff [GWP_PORTS];
  logic [7:0] port_rd [GWP_PORTS];
  logic [7:0] width_mask [GWP_PORTS];

  assign pin_in[0] = PA_I;
  assign pin_in[1] = PB_I;
  assign pin_in[2] = PC_I;
  assign pin_in[3] = PD_I;
  assign pin_in[4] = {1'b1, PE_I};

  genvar p;
  generate
    for (p = 0; p < GWP_PORTS; p++) begin : g_port
      localparam logic [7:0] DATA_ADDR = 8'(GWP_OFF_DATA_BASE + GWP_OFF_STEP * p);
      localparam logic [7:0] DIR_ADDR = 8'(GWP_OFF_DIR_BASE + GWP_OFF_STEP * p);
      logic [7:0] wdata;

      assign width_mask[p] = (p == GWP_PORT_E) ? GWP_E_MASK : 8'hFF;
      assign wdata = HWDATA[7:0] & width_mask[p];

      // Latch holds until the next write
      always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
          data_ff[p] <= GWP_PORT_RST;
        end else if (wr_commit && req_ff.addr == DATA_ADDR) begin
          data_ff[p] <= wdata;
        end
      end

      always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
          dir_ff[p] <= GWP_DIR_RST;
          oe_ff[p] <= 8'h00;
        end else if (wr_commit && req_ff.addr == DIR_ADDR) begin
          dir_ff[p] <= wdata;
          oe_ff[p] <= ~wdata & width_mask[p];
        end
      end

      always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
          meta_ff[p] <= 8'hFF;
          sync_ff[p] <= 8'hFF;
          prev_ff[p] <= 8'hFF;
        end else begin
          meta_ff[p] <= pin_in[p];
          sync_ff[p] <= meta_ff[p];
          prev_ff[p] <= sync_ff[p];
        end
      end

      // Inputs read live; outputs read back from the latch
      assign port_rd[p] = ((dir_ff[p] & sync_ff[p]) | (~dir_ff[p] & data_ff[p]))
                          & width_mask[p];
    end
  endgenerate

  assign PA_O = data_ff[0];
  assign PA_OE = oe_ff[0];
  assign PB_O = data_ff[1];
  assign PB_OE = oe_ff[1];
  assign PC_O = data_ff[2];
  assign PC_OE = oe_ff[2];
  assign PD_O = data_ff[3];
  assign PD_OE = oe_ff[3];
  assign PE_O = data_ff[4][6:0];
  assign PE_OE = oe_ff[4][6:0];

  // Timer input follows line A2 always; keeping it harmless when
  // used as plain I/O is up to the timer mode setting.
  assign TIMER_IN = sync_ff[0][GWP_TMR_LINE];

  // ----------------------------------------------------------------
  // Wake detection
  // ----------------------------------------------------------------
  logic halt_ff;
  logic [7:0] nib_sel_ff;
  logic [7:0] nib_now;
  logic [7:0] nib_prev;
  logic [7:0] nib_fall;
  logic [6:0] line_edge;
  logic wake_any;

  genvar n;
  generate
    for (n = 0; n < GWP_NIBBLES; n++) begin : g_nib
      // Nibble level is the AND of its pins, so one low pin blocks it
      assign nib_now[n] = &sync_ff[n / 2][(n % 2) * 4 +: 4];
      assign nib_prev[n] = &prev_ff[n / 2][(n % 2) * 4 +: 4];
    end
  endgenerate

  assign nib_fall = nib_prev & ~nib_now & nib_sel_ff & {8{halt_ff}};
  assign line_edge = (prev_ff[4][6:0] ^ sync_ff[4][6:0]) & E_WAKE_OPT
                     & {7{halt_ff}};
  // Timer overflow has no path in here by design
  assign wake_any = |nib_fall | |line_edge;

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      halt_ff <= 1'b0;
    end else if (wake_any) begin
      halt_ff <= 1'b0;
    end else if (wr_commit && req_ff.addr == GWP_OFF_HALT && HWDATA[0]) begin
      halt_ff <= 1'b1;
    end
  end

  assign PWR_DOWN = halt_ff;

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      nib_sel_ff <= GWP_NIB_SEL_RST;
    end else if (wr_commit && req_ff.addr == GWP_OFF_NIB_SEL) begin
      nib_sel_ff <= HWDATA[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Wake flags
  // ----------------------------------------------------------------
  logic [7:0] flag_ff;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;

  always_comb begin
    flag_set = 8'h00;
    flag_set[GWP_FLAG_V1] = line_edge[0];
    flag_set[GWP_FLAG_V2] = line_edge[1];
    flag_set[GWP_FLAG_Z1] = line_edge[2];
    flag_set[GWP_FLAG_Z2] = line_edge[3];
    flag_clr = 8'h00;
    if (rd_cap && req_ff.addr == GWP_OFF_DATA_BASE + GWP_OFF_STEP * 3'd4) begin
      flag_clr = GWP_FLAG_PIN_CLR;
    end else if (rd_cap && req_ff.addr == GWP_OFF_FLAGS) begin
      flag_clr = GWP_FLAG_SELF_CLR;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      flag_ff <= 8'h00;
    end else begin
      flag_ff <= (flag_ff & ~flag_clr) | flag_set;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  logic [1:0] stat_ff;
  logic [1:0] mask_ff;
  logic [1:0] stat_set;
  logic irq_ff;

  assign stat_set = {|line_edge, |nib_fall};

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      stat_ff <= 2'h0;
      mask_ff <= GWP_IRQ_MASK_RST;
      irq_ff <= 1'b0;
    end else begin
      if (rd_cap && req_ff.addr == GWP_OFF_IRQ_STAT) begin
        stat_ff <= stat_set;
      end else begin
        stat_ff <= stat_ff | stat_set;
      end
      if (wr_commit && req_ff.addr == GWP_OFF_IRQ_MASK) begin
        mask_ff <= HWDATA[1:0];
      end
      irq_ff <= |(stat_ff & mask_ff);
    end
  end

  assign IRQ = irq_ff;

  // ----------------------------------------------------------------
  // Read mux; bit set/clear is a software whole-word rewrite
  // ----------------------------------------------------------------
  always_comb begin
    rd_val = 32'h0000_0000;
    case (req_ff.addr)
      GWP_OFF_FLAGS: rd_val[7:0] = flag_ff;
      GWP_OFF_HALT: rd_val[0] = halt_ff;
      GWP_OFF_NIB_SEL: rd_val[7:0] = nib_sel_ff;
      GWP_OFF_IRQ_STAT: rd_val[1:0] = stat_ff;
      GWP_OFF_IRQ_MASK: rd_val[1:0] = mask_ff;
      default: begin
        for (int i = 0; i < GWP_PORTS; i++) begin
          if (req_ff.addr == 8'(GWP_OFF_DATA_BASE + GWP_OFF_STEP * i)) begin
            rd_val[7:0] = port_rd[i];
          end
          if (req_ff.addr == 8'(GWP_OFF_DIR_BASE + GWP_OFF_STEP * i)) begin
            rd_val[7:0] = dir_ff[i] & width_mask[i];
          end
        end
      end
    endcase
  end

endmodule

/* File: gwp_pins.sv */
`timescale 1ns/1ps
module gwp_pins (
  input wire logic [38:0] drv_o,
  input wire logic [38:0] drv_oe,
  input wire logic [38:0] sw,
  output logic [38:0] lvl
);
  // Driven pins follow the port, released pins show the switch
  assign lvl = (drv_oe & drv_o) | (~drv_oe & sw);
endmodule

/* File: gwp_port_checker.sv */
`timescale 1ns/1ps
module gwp_port_checker
  import gwp_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic [7:0] PA_I,
  input wire logic [7:0] PB_I,
  input wire logic [7:0] PC_I,
  input wire logic [7:0] PD_I,
  input wire logic [6:0] PE_I,
  input wire logic [7:0] PA_O,
  input wire logic [7:0] PA_OE,
  input wire logic [6:0] PE_O,
  input wire logic [6:0] PE_OE,
  input wire logic TIMER_IN,
  input wire logic PWR_DOWN
);
  logic wr_go;
  logic rd_go;
  logic [38:0] pins_ff;
  logic [3:0] quiet_ff;
  assign wr_go = HSEL & HTRANS[1] & HREADY & HWRITE;
  assign rd_go = HSEL & HTRANS[1] & HREADY & !HWRITE;
  // Cycles since any pin moved; a wake needs a recent pin edge
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pins_ff <= '1;
      quiet_ff <= 4'hF;
    end else begin
      pins_ff <= {PE_I, PD_I, PC_I, PB_I, PA_I};
      if ({PE_I, PD_I, PC_I, PB_I, PA_I} != pins_ff) begin
        quiet_ff <= 4'h0;
      end else if (quiet_ff != 4'hF) begin
        quiet_ff <= quiet_ff + 4'h1;
      end
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  rst_ones_a: assert property ($fell(SYS_RST) |-> PA_O == 8'hFF && PA_OE == 8'h00
    && PE_OE == 7'h00) else $error("Port not in reset state");
  oe_change_a: assert property (!$stable({PA_OE, PE_OE}) |-> $past(wr_go, 2))
    else $error("Direction changed without a write");
  out_change_a: assert property (!$stable({PA_O, PE_O}) |-> $past(wr_go, 2))
    else $error("Output latch changed without a write");
  halt_entry_a: assert property ($rose(PWR_DOWN) |-> $past(wr_go, 2) && $past(HWDATA[0])
    && $past(HADDR[7:0], 2) == GWP_OFF_HALT) else $error("Power down without halt write");
  wake_cause_a: assert property ($fell(PWR_DOWN) |-> quiet_ff < 4'hA)
    else $error("Wake without a pin edge");
  read_wait_a: assert property (rd_go |=> !HREADYOUT ##1 HREADYOUT)
    else $error("Read wait state wrong");
  write_nowait_a: assert property (wr_go |=> HREADYOUT) else $error("Write stalled");
  resp_okay_a: assert property (HRESP == 1'b0) else $error("Response not OKAY");
  timer_pin_a: assert property ($changed(TIMER_IN) |-> TIMER_IN == $past(PA_I[2], 2)
    || TIMER_IN == $past(PA_I[2], 3)) else $error("Timer input not following pin");
  halt_c: cover property ($rose(PWR_DOWN));
  wake_c: cover property ($fell(PWR_DOWN));
  read_c: cover property (rd_go ##2 HREADYOUT);
endmodule
bind gwp_port gwp_port_checker chk (.*);

/* File: gwp_port_bench.sv */
`timescale 1ns/1ps
module gwp_port_bench
  import gwp_pkg::*;
;
  logic clk = 0;
  logic rst = 1;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic hwrite = 0;
  logic hready;
  logic [31:0] hrdata;
  logic [39:0] sw = '1;
  logic [38:0] lvl;
  logic [39:0] po;
  logic [39:0] poe;
  logic pwr;
  logic irq;
  logic [31:0] v;
  logic [7:0] m;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  integer seed = 32'hfedc;
  int dat[5] = '{255, 255, 255, 255, 255};
  int dir[5] = '{255, 255, 255, 255, 255};
  gwp_port DUT (.REF_CLK(clk), .SYS_RST(rst), .HSEL(1'h1), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hready),
    .HRDATA(hrdata), .HRESP(), .PA_I(lvl[7:0]), .PA_O(po[7:0]), .PA_OE(poe[7:0]),
    .PB_I(lvl[15:8]), .PB_O(po[15:8]), .PB_OE(poe[15:8]), .PC_I(lvl[23:16]),
    .PC_O(po[23:16]), .PC_OE(poe[23:16]), .PD_I(lvl[31:24]), .PD_O(po[31:24]),
    .PD_OE(poe[31:24]), .PE_I(lvl[38:32]), .PE_O(po[38:32]), .PE_OE(poe[38:32]),
    .TIMER_IN(), .PWR_DOWN(pwr), .IRQ(irq));
  gwp_pins pins (.drv_o(po[38:0]), .drv_oe(poe[38:0]), .sw(sw[38:0]), .lvl(lvl));
  always #10 clk = ~clk;
  task automatic tally_and_finish();
    $display("Counts: %0d compares, %0d mismatches", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    v = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    xfer(a, 0, 32'h0);
    chk(n, e, v);
  endtask
  // Model of a data read: latch where driven, pin where input
  function automatic logic [31:0] pexp(int p);
    logic [7:0] k;
    k = p == 4 ? 8'h7F : 8'hFF;
    return {24'h0, (dat[p][7:0] & ~dir[p][7:0] | sw[p*8 +: 8] & dir[p][7:0]) & k};
  endfunction
  task automatic halt_poke(input int b, input logic lv, input logic woke, input logic [7:0] f);
    xfer(GWP_OFF_HALT, 1, 32'h1);
    repeat (2) @(posedge clk);
    chk("power down", 1, pwr);
    sw[b] <= lv;
    repeat (10) @(posedge clk);
    chk("still halted", !woke, pwr);
    rd(GWP_OFF_FLAGS, f, "wake flags");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    for (int p = 0; p < 5; p++) begin
      m = p == 4 ? 8'h7F : 8'hFF;
      rd(8'(4 * p), pexp(p), "data reset");
      rd(8'(32 + 4 * p), {24'h0, m}, "dir reset");
      chk("latch reset", {24'h0, m}, {24'h0, po[p*8 +: 8] & m});
      chk("oe reset", 0, {24'h0, poe[p*8 +: 8] & m});
    end
    rd(8'h60, 32'h0, "unmapped");
    $display("test reset done");
    for (int p = 0; p < 5; p++) begin
      m = p == 4 ? 8'h7F : 8'hFF;
      dat[p] = $random(seed);
      dir[p] = $random(seed);
      sw[31:0] <= $random(seed);
      v = $random(seed);
      sw[39:32] <= v[7:0];
      xfer(8'(4 * p), 1, dat[p]);
      xfer(8'(32 + 4 * p), 1, dir[p]);
      repeat (3) @(posedge clk);
      rd(8'(4 * p), pexp(p), "port read");
      chk("oe", {24'h0, ~dir[p][7:0] & m}, {24'h0, poe[p*8 +: 8] & m});
      chk("latch", {24'h0, dat[p][7:0] & m}, {24'h0, po[p*8 +: 8] & m});
    end
    $display("test direction done");
    xfer(8'h24, 0, 32'h0);
    xfer(8'h24, 1, v | 32'h8);
    dir[1] = dir[1] | 8;
    rd(8'h24, {24'h0, dir[1][7:0]}, "bit set");
    $display("test modify done");
    dir[0] = 255;
    dir[4] = 255;
    sw <= '1;
    xfer(8'h20, 1, 32'hFF);
    xfer(8'h30, 1, 32'h7F);
    xfer(GWP_OFF_NIB_SEL, 1, 32'h1);
    halt_poke(0, 0, 1, 8'h00);
    chk("masked irq", 0, irq);
    xfer(GWP_OFF_IRQ_MASK, 1, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq", 1, irq);
    rd(GWP_OFF_IRQ_STAT, 32'h1, "irq status");
    repeat (2) @(posedge clk);
    chk("irq cleared", 0, irq);
    halt_poke(1, 0, 0, 8'h00);
    halt_poke(32, 0, 1, 8'h08);
    rd(GWP_OFF_FLAGS, 32'h8, "flag kept");
    rd(8'h10, pexp(4), "line read");
    rd(GWP_OFF_FLAGS, 32'h0, "flag cleared");
    halt_poke(34, 0, 1, 8'h40);
    rd(GWP_OFF_FLAGS, 32'h0, "self clear");
    sw[35] <= 0;
    halt_poke(35, 1, 1, 8'h80);
    halt_poke(36, 0, 0, 8'h00);
    halt_poke(33, 0, 1, 8'h10);
    rd(GWP_OFF_HALT, 32'h0, "halt state");
    rd(GWP_OFF_NIB_SEL, 32'h1, "nibble select");
    rd(GWP_OFF_IRQ_STAT, 32'h2, "line status");
    chk("line irq masked", 0, irq);
    $display("test wake done");
    tally_and_finish();
  end
endmodule
